//--- fsw_pkg.sv
// Shared constants and types for the serial flash status front end.
// Assumes one serial link clock and one system clock, unrelated in phase.
package fsw_pkg;

	localparam int ADDR_W = 24;

	// Command codes; only the status write and whole-array erase codes
	// were fixed, the rest follow the usual serial flash convention.
	localparam logic [7:0] OP_WRITE_ENABLE    = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE   = 8'h04;
	localparam logic [7:0] OP_STATUS_READ     = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE    = 8'h01;
	localparam logic [7:0] OP_ARRAY_ERASE     = 8'hc7;
	localparam logic [7:0] OP_ARRAY_ERASE_ALT = 8'h60;
	localparam logic [7:0] OP_PAGE_PROGRAM    = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE    = 8'h20;
	localparam logic [7:0] OP_SECTOR_ERASE2   = 8'hd7;
	localparam logic [7:0] OP_BLOCK32_ERASE   = 8'h52;
	localparam logic [7:0] OP_BLOCK64_ERASE   = 8'hd8;

	// Status register layout
	localparam int ST_BUSY    = 0;
	localparam int ST_WEL     = 1;
	localparam int ST_PROT_LO = 2;
	localparam int ST_PROT_HI = 5;
	localparam int ST_QUAD    = 6;
	localparam int ST_LOCK    = 7;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [3:0] PROT_NONE    = 4'h0;

	// Erase granules as log2 of their byte size
	localparam logic [4:0] SECTOR_LOG2  = 5'd12;
	localparam logic [4:0] BLOCK32_LOG2 = 5'd15;
	localparam logic [4:0] BLOCK64_LOG2 = 5'd16;
	localparam logic [4:0] ARRAY_LOG2   = 5'd23;
	localparam logic [ADDR_W-1:0] ARRAY_TOP = 24'h7fffff;

	// Frame framing
	localparam logic [2:0] BYTE_BITS_M1 = 3'h7;
	localparam logic [2:0] LEN_OP       = 3'h1;
	localparam logic [2:0] LEN_DATA     = 3'h2;
	localparam logic [2:0] LEN_ADDR     = 3'h4;
	localparam logic [2:0] LEN_PROG     = 3'h5;
	localparam logic [2:0] LEN_SAT      = 3'h7;
	localparam logic [3:0] OE_SINGLE    = 4'h2;
	localparam logic [3:0] OE_QUAD      = 4'hf;

	typedef enum logic [1:0] {
		FSW_IDLE = 2'b01,
		FSW_BUSY = 2'b10
	} fsw_state_t;

	typedef enum logic [3:0] {
		FSW_KIND_STATUS = 4'b0001,
		FSW_KIND_PROG   = 4'b0010,
		FSW_KIND_ERASE  = 4'b0100,
		FSW_KIND_ALL    = 4'b1000
	} fsw_kind_t;

	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} fsw_lanes_t;

	typedef struct packed {
		logic [7:0]        op;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
		logic [2:0]        bytes;
		logic              ragged;
	} fsw_frame_t;

	typedef struct packed {
		logic [7:0] status;
		logic       quad_lanes;
		logic       quad_cmd;
	} fsw_link_cfg_t;

	typedef struct packed {
		logic              start;
		fsw_kind_t         kind;
		logic [ADDR_W-1:0] base;
		logic [4:0]        size_log2;
	} fsw_array_op_t;

endpackage

//--- fsw_status_front.sv
// Serial link front end and status register of a serial flash.
// Assumes a master on sck/cs_n in clock mode 0 or 3 and an array engine
// beside it that takes array_op; busy time is modelled by a counter.
`timescale 1ns/1ps
module fsw_status_front
	import fsw_pkg::*;
#(
	parameter int BUSY_CYCLES = 64
) (
	input  wire logic                   mclk,
	input  wire logic                   rstn,
	input  wire logic                   sck,
	input  wire logic                   cs_n,
	input  wire logic [3:0]             lane_in,
	output fsw_pkg::fsw_lanes_t         lanes,
	input  wire logic                   quad_command_mode,
	output fsw_pkg::fsw_array_op_t      array_op,
	output logic [7:0]                  flash_status
);
	import fsw_pkg::*;

	logic          rst_meta;
	logic          rst_n;
	fsw_link_cfg_t cfg;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Link domain. The frame counters clear on chip select high; the
	// captured frame survives it so the system side can read it later.
	logic       hold_ok;
	logic       quad_now;
	logic [2:0] bit_cnt;
	logic [2:0] byte_idx;
	logic [7:0] sh;
	logic [7:0] next_sh;
	logic [2:0] next_bit_cnt;
	logic       byte_done;
	logic       frame_tog;
	logic       rd_arm;
	fsw_frame_t frame;

	assign quad_now = cfg.quad_cmd;
	// Pause pin only acts while it is not a data lane
	assign hold_ok  = cfg.quad_lanes | quad_now | lane_in[3];

	always_comb begin
		if (quad_now) begin
			next_sh      = {sh[3:0], lane_in};
			next_bit_cnt = bit_cnt + 3'h4;
		end else begin
			next_sh      = {sh[6:0], lane_in[0]};
			next_bit_cnt = bit_cnt + 3'h1;
		end
		byte_done = (next_bit_cnt == 3'h0);
	end

	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt  <= 3'h0;
			byte_idx <= 3'h0;
			sh       <= 8'h00;
		end else if (hold_ok) begin
			bit_cnt <= next_bit_cnt;
			sh      <= next_sh;
			if (byte_done && byte_idx != LEN_SAT) begin
				byte_idx <= byte_idx + 3'h1;
			end
		end
	end

	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			rd_arm <= 1'b0;
		end else if (hold_ok && byte_done && byte_idx == 3'h0) begin
			rd_arm <= (next_sh == OP_STATUS_READ);
		end
	end

	// Address arrives high byte first in bytes 1..3
	always_ff @(posedge sck or negedge rst_n) begin
		if (!rst_n) begin
			frame     <= '0;
			frame_tog <= 1'b0;
		end else if (!cs_n && hold_ok) begin
			if (bit_cnt == 3'h0 && byte_idx == 3'h0) begin
				frame_tog   <= ~frame_tog;
				frame.bytes <= 3'h0;
			end
			frame.ragged <= ~byte_done;
			if (byte_done) begin
				// Long frames saturate instead of wrapping to zero
				frame.bytes <= (byte_idx == LEN_SAT) ? LEN_SAT :
					byte_idx + 3'h1;
				unique case (byte_idx)
					3'h0: frame.op <= next_sh;
					3'h1: begin
						frame.data                 <= next_sh;
						frame.addr[ADDR_W-1 -: 8] <= next_sh;
					end
					3'h2: frame.addr[15:8] <= next_sh;
					3'h3: frame.addr[7:0]  <= next_sh;
					default: ;
				endcase
			end
		end
	end

	// Output launch. The same byte wraps for as long as clocks keep coming.
	logic       rd_live;
	logic [2:0] out_pos;
	logic [3:0] lane_out;
	logic [3:0] lane_oe;

	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			rd_live  <= 1'b0;
			out_pos  <= 3'h0;
			lane_out <= 4'h0;
		end else if (rd_arm && hold_ok) begin
			rd_live <= 1'b1;
			if (quad_now) begin
				lane_out <= out_pos[0] ? cfg.status[3:0] : cfg.status[7:4];
				out_pos  <= {2'b00, ~out_pos[0]};
			end else begin
				lane_out <= {2'b00, cfg.status[BYTE_BITS_M1 - out_pos], 1'b0};
				out_pos  <= out_pos + 3'h1;
			end
		end
	end

	assign lane_oe = (rd_live && !cs_n && hold_ok) ?
		(quad_now ? OE_QUAD : OE_SINGLE) : 4'h0;
	assign lanes   = '{out: lane_out, oe: lane_oe};

	// System domain
	logic          cs_meta;
	logic          cs_s2;
	logic          cs_s3;
	logic          tog_meta;
	logic          tog_s2;
	logic          tog_seen;
	logic          wp_meta;
	logic          wp_s2;
	logic          qcm_meta;
	logic          qcm_s2;
	logic          exec;
	logic          wp_high;
	logic          busy_flag;
	logic          write_enable_latch;
	logic [3:0]    protect_level;
	logic          quad_lane_enable;
	logic          status_write_lock;
	fsw_state_t    state;
	logic [$clog2(BUSY_CYCLES+1)-1:0] busy_cnt;
	logic          start_ok;
	fsw_kind_t     next_kind;
	logic [4:0]    next_size;
	logic          is_write;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cs_meta  <= 1'b1;
			cs_s2    <= 1'b1;
			cs_s3    <= 1'b1;
			tog_meta <= 1'b0;
			tog_s2   <= 1'b0;
			wp_meta  <= 1'b1;
			wp_s2    <= 1'b1;
			qcm_meta <= 1'b0;
			qcm_s2   <= 1'b0;
		end else begin
			cs_meta  <= cs_n;
			cs_s2    <= cs_meta;
			cs_s3    <= cs_s2;
			tog_meta <= frame_tog;
			tog_s2   <= tog_meta;
			wp_meta  <= lane_in[2];
			wp_s2    <= wp_meta;
			qcm_meta <= quad_command_mode;
			qcm_s2   <= qcm_meta;
		end
	end

	// Frame regs are stable once chip select high has been synchronised
	assign exec    = cs_s2 && !cs_s3 && (tog_s2 != tog_seen);
	assign wp_high = quad_lane_enable | cfg.quad_cmd | wp_s2;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tog_seen <= 1'b0;
		end else if (exec) begin
			tog_seen <= tog_s2;
		end
	end

	always_comb begin
		is_write  = 1'b1;
		start_ok  = 1'b0;
		next_kind = FSW_KIND_ERASE;
		next_size = SECTOR_LOG2;
		unique case (frame.op)
			OP_STATUS_WRITE: begin
				next_kind = FSW_KIND_STATUS;
				start_ok  = frame.bytes >= LEN_DATA &&
					!(status_write_lock && !wp_high);
			end
			OP_PAGE_PROGRAM: begin
				next_kind = FSW_KIND_PROG;
				start_ok  = frame.bytes >= LEN_PROG;
			end
			OP_SECTOR_ERASE, OP_SECTOR_ERASE2: begin
				start_ok = frame.bytes == LEN_ADDR;
			end
			OP_BLOCK32_ERASE: begin
				next_size = BLOCK32_LOG2;
				start_ok  = frame.bytes == LEN_ADDR;
			end
			OP_BLOCK64_ERASE: begin
				next_size = BLOCK64_LOG2;
				start_ok  = frame.bytes == LEN_ADDR;
			end
			OP_ARRAY_ERASE, OP_ARRAY_ERASE_ALT: begin
				next_kind = FSW_KIND_ALL;
				next_size = ARRAY_LOG2;
				start_ok  = frame.bytes == LEN_OP &&
					protect_level == PROT_NONE;
			end
			default: is_write = 1'b0;
		endcase
	end

	logic start;
	// Write-type work needs the latch and an idle engine
	assign start = exec && !frame.ragged && is_write && start_ok &&
		write_enable_latch && state == FSW_IDLE;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state    <= FSW_IDLE;
			busy_cnt <= '0;
		end else begin
			unique case (state)
				FSW_IDLE: if (start) begin
					state    <= FSW_BUSY;
					busy_cnt <= '0;
				end
				FSW_BUSY: if (busy_cnt == BUSY_CYCLES[$bits(busy_cnt)-1:0]) begin
					state <= FSW_IDLE;
				end else begin
					busy_cnt <= busy_cnt + 1'b1;
				end
			endcase
		end
	end

	assign busy_flag = (state == FSW_BUSY);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			write_enable_latch <= 1'b0;
		end else if (busy_flag && busy_cnt ==
				BUSY_CYCLES[$bits(busy_cnt)-1:0]) begin
			write_enable_latch <= 1'b0;
		end else if (exec && !frame.ragged && frame.bytes == LEN_OP &&
				!busy_flag) begin
			if (frame.op == OP_WRITE_ENABLE) begin
				write_enable_latch <= 1'b1;
			end else if (frame.op == OP_WRITE_DISABLE) begin
				write_enable_latch <= 1'b0;
			end
		end
	end

	// Kept bits reset to their factory value; status write needs the latch like the other writes
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			protect_level     <= STATUS_RESET[ST_PROT_HI:ST_PROT_LO];
			quad_lane_enable  <= STATUS_RESET[ST_QUAD];
			status_write_lock <= STATUS_RESET[ST_LOCK];
		end else if (start && next_kind == FSW_KIND_STATUS) begin
			protect_level     <= frame.data[ST_PROT_HI:ST_PROT_LO];
			quad_lane_enable  <= frame.data[ST_QUAD];
			status_write_lock <= frame.data[ST_LOCK];
		end
	end

	always_comb begin
		flash_status              = STATUS_RESET;
		flash_status[ST_BUSY]     = busy_flag;
		flash_status[ST_WEL]      = write_enable_latch;
		flash_status[ST_PROT_HI:ST_PROT_LO] = protect_level;
		flash_status[ST_QUAD]     = quad_lane_enable;
		flash_status[ST_LOCK]     = status_write_lock;
	end

	// Snapshot seen by the link is frozen while selected, so a busy poll
	// needs a new frame to see completion; the link never samples a moving word.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg <= '0;
		end else if (cs_s2 && cs_s3) begin
			cfg.status     <= flash_status;
			cfg.quad_lanes <= quad_lane_enable;
			cfg.quad_cmd   <= qcm_s2;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			array_op <= '{start: 1'b0, kind: FSW_KIND_ERASE, base: '0,
				size_log2: SECTOR_LOG2};
		end else begin
			array_op.start <= start && next_kind != FSW_KIND_STATUS;
			if (start) begin
				array_op.kind      <= next_kind;
				array_op.size_log2 <= next_size;
				// Align erases to the natural boundary of the granule; page program keeps its address masked to ARRAY_TOP
				array_op.base <= (next_kind == FSW_KIND_PROG) ?
					(frame.addr & ARRAY_TOP) :
					(frame.addr & ARRAY_TOP &
					~((24'h1 << next_size) - 24'h1));
			end
		end
	end

	chk_wel_set: assert property (@(posedge mclk) disable iff (!rst_n)
		exec && !frame.ragged && frame.bytes == LEN_OP && !busy_flag &&
		frame.op == OP_WRITE_ENABLE |=> write_enable_latch)
		else $error("write enable did not set the latch");

	chk_wel_clear: assert property (@(posedge mclk) disable iff (!rst_n)
		exec && !frame.ragged && frame.bytes == LEN_OP && !busy_flag &&
		frame.op == OP_WRITE_DISABLE |=> !write_enable_latch)
		else $error("write disable did not clear the latch");

	chk_status_keeps_wel: assert property (@(posedge mclk)
		disable iff (!rst_n)
		start && next_kind == FSW_KIND_STATUS |=>
		write_enable_latch == $past(write_enable_latch))
		else $error("status write changed the latch");

	chk_no_write_unlatched: assert property (@(posedge mclk)
		disable iff (!rst_n)
		$rose(busy_flag) |-> $past(write_enable_latch))
		else $error("write started without the latch");

	chk_done_clears_wel: assert property (@(posedge mclk)
		disable iff (!rst_n)
		$fell(busy_flag) |-> !write_enable_latch)
		else $error("latch still set after completion");

	chk_array_erase_prot: assert property (@(posedge mclk)
		disable iff (!rst_n)
		array_op.start && array_op.kind == FSW_KIND_ALL |->
		$past(protect_level) == PROT_NONE)
		else $error("whole array erase while protected");

	chk_lock_holds: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(status_write_lock) && !$past(wp_high) |->
		$stable(protect_level) && $stable(quad_lane_enable) &&
		$stable(status_write_lock))
		else $error("locked status bits changed");

	chk_busy_start: assert property (@(posedge mclk) disable iff (!rst_n)
		start |-> !busy_flag ##1 busy_flag [*2])
		else $error("busy flag not raised for a started write");

	chk_status_read: assert property (@(negedge sck) disable iff (cs_n)
		rd_live && !quad_now && out_pos == 3'h1 |->
		lanes.out[1] == cfg.status[BYTE_BITS_M1])
		else $error("status byte does not restart at its top bit");

	chk_sector_align: assert property (@(posedge mclk)
		disable iff (!rst_n)
		array_op.start && array_op.kind == FSW_KIND_ERASE |->
		array_op.base[11:0] == 12'h000)
		else $error("erase base not sector aligned");

endmodule // fsw_status_front

//--- fsw_spi_master.sv
// Behavioural serial master that drives the flash front end's link pins.
// Assumes the device samples on rising sck and launches on falling sck.
`timescale 1ns/1ps
module fsw_spi_master (
	output logic        sck,
	output logic        cs_n,
	output logic        mosi,
	input  wire logic   miso,
	output logic [3:0]  q_out,
	output logic        q_en,
	input  wire logic [3:0] q_in
);
	logic        mode3 = 1'b0;
	logic [15:0] rx;

	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
		q_out = 4'h0;
		q_en = 1'b0;
	end

	// Sends nbits from bit 39 down; the last 16 bits seen on miso land in rx
	task automatic frame(input logic [39:0] tx, input int nbits);
		logic [39:0] sh;
		sh = tx;
		rx = 16'h0;
		sck = mode3;
		#40 cs_n = 1'b0;
		#40;
		for (int i = 0; i < nbits; i++) begin
			sck = 1'b0;
			mosi = sh[39];
			sh = sh << 1;
			#40 sck = 1'b1;
			rx = {rx[14:0], miso};
			#40;
		end
		// Clock stands at its idle level between frames
		sck = mode3;
		#40 cs_n = 1'b1;
		// Released data line must not keep showing the last bit
		mosi = ~mosi;
		#200;
	endtask

	// Four-lane frame: first two nibbles driven, the last four land in rx
	task automatic qframe(input logic [15:0] tx, input int nnib);
		logic [15:0] sh;
		sh = tx;
		rx = 16'h0;
		sck = mode3;
		#40 cs_n = 1'b0;
		#40;
		for (int i = 0; i < nnib; i++) begin
			sck = 1'b0;
			q_en = (i < 2);
			q_out = sh[15:12];
			sh = sh << 4;
			#40 sck = 1'b1;
			rx = {rx[11:0], q_in};
			#40;
		end
		sck = mode3;
		#40 cs_n = 1'b1;
		q_en = 1'b0;
		#200;
	endtask
endmodule // fsw_spi_master

//--- testbench.sv
// Self-checking bench for the flash status front end.
// Assumes the serial master model drives the link at an 80 ns clock.
`timescale 1ns/1ps
module testbench;
	import fsw_pkg::*;
	localparam int BUSY_N = 8;
	logic          mclk = 1'b0;
	logic          rstn = 1'b0;
	logic          wp = 1'b1;
	logic          quad_cmd = 1'b0;
	wire           sck;
	wire           cs_n;
	wire           mosi;
	wire [3:0]     lane_in;
	wire [3:0]     q_out;
	wire           q_en;
	fsw_lanes_t    lanes;
	fsw_array_op_t array_op;
	logic [7:0]    flash_status;
	logic          busy_seen;
	int            err_total = 0;
	int            check_count = 0;
	int            n_start = 0;
	int            cycles = 0;

	always #12.5 mclk = ~mclk;

	// Device drive wins, then the master's quad drive; an undriven
	// lane 1 shows the inverse of lanes.out[1]; lanes 0, 2 and 3 show mosi, wp and 1
	assign lane_in[0] = lanes.oe[0] ? lanes.out[0] : q_en ? q_out[0] : mosi;
	assign lane_in[1] = lanes.oe[1] ? lanes.out[1] :
		q_en ? q_out[1] : ~lanes.out[1];
	assign lane_in[2] = lanes.oe[2] ? lanes.out[2] : q_en ? q_out[2] : wp;
	assign lane_in[3] = lanes.oe[3] ? lanes.out[3] : q_en ? q_out[3] : 1'b1;

	fsw_status_front #(.BUSY_CYCLES(BUSY_N)) i_dut (.mclk(mclk), .rstn(rstn),
		.sck(sck), .cs_n(cs_n), .lane_in(lane_in), .lanes(lanes),
		.quad_command_mode(quad_cmd), .array_op(array_op),
		.flash_status(flash_status));

	fsw_spi_master i_master (.sck(sck), .cs_n(cs_n), .mosi(mosi),
		.miso(lane_in[1]), .q_out(q_out), .q_en(q_en), .q_in(lane_in));

	always @(posedge mclk) begin
		cycles++;
		if (array_op.start === 1'b1) begin
			n_start++;
			busy_seen <= flash_status[0];
		end
		if (cycles == 20000) begin
			err_total++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wait_idle();
		int k;
		k = 0;
		while (flash_status[0] !== 1'b0 && k < 200) begin
			@(negedge mclk);
			k++;
		end
		check(32'(k < 200), 32'h1);
	endtask

	task automatic cmd(input logic [7:0] op);
		i_master.frame({op, 32'h0}, 8);
	endtask

	task automatic read_status(input logic [7:0] exp);
		i_master.frame({OP_STATUS_READ, 32'h0}, 24);
		check(32'(i_master.rx), {16'h0, exp, exp});
	endtask

	task automatic wr_status(input logic [7:0] d);
		cmd(OP_WRITE_ENABLE);
		i_master.frame({OP_STATUS_WRITE, d, 24'h0}, 16);
		wait_idle();
	endtask

	task automatic t_reset();
		check(32'(flash_status), 32'(STATUS_RESET));
		check(32'(array_op.start), 32'h0);
		$display("test reset done");
	endtask

	task automatic t_latch();
		for (int m = 0; m < 2; m++) begin
			i_master.mode3 = m[0];
			read_status(8'h00);
			cmd(OP_WRITE_ENABLE);
			check(32'(flash_status), 32'h02);
			read_status(8'h02);
			cmd(OP_WRITE_DISABLE);
			check(32'(flash_status), 32'h00);
		end
		i_master.mode3 = 1'b0;
		$display("test latch done");
	endtask

	task automatic t_refuse();
		int n0;
		n0 = n_start;
		i_master.frame({OP_STATUS_WRITE, 8'h3c, 24'h0}, 16);
		i_master.frame({OP_SECTOR_ERASE, 24'h001000, 8'h0}, 32);
		repeat (20) @(negedge mclk);
		check(32'(flash_status), 32'h00);
		check(n_start, n0);
		$display("test refuse done");
	endtask

	task automatic t_status();
		int n0;
		wr_status(8'h7e);
		check(32'(flash_status), 32'h7c);
		read_status(8'h7c);
		n0 = n_start;
		cmd(OP_WRITE_ENABLE);
		cmd(OP_ARRAY_ERASE);
		repeat (20) @(negedge mclk);
		check(n_start, n0);
		cmd(OP_WRITE_DISABLE);
		@(negedge mclk) wp = 1'b0;
		wr_status(8'h80);
		check(32'(flash_status), 32'h80);
		wr_status(8'h00);
		check(32'(flash_status[7:2]), 32'h20);
		cmd(OP_WRITE_DISABLE);
		@(negedge mclk) wp = 1'b1;
		wr_status(8'h00);
		check(32'(flash_status), 32'h00);
		wr_status(8'hc0);
		check(32'(flash_status), 32'hc0);
		@(negedge mclk) wp = 1'b0;
		wr_status(8'h00);
		check(32'(flash_status), 32'h00);
		@(negedge mclk) wp = 1'b1;
		$display("test status done");
	endtask

	task automatic t_erase();
		logic [7:0] ops [6];
		int         nb [6];
		logic [4:0] sz [6];
		int         n0;
		int         k;
		ops = '{8'h20, 8'hd7, 8'h52, 8'hd8, 8'hc7, 8'h02};
		nb = '{32, 32, 32, 32, 8, 40};
		sz = '{5'd12, 5'd12, 5'd15, 5'd16, 5'd23, 5'd0};
		for (int i = 0; i < 6; i++) begin
			i_master.mode3 = i[0];
			n0 = n_start;
			cmd(OP_WRITE_ENABLE);
			i_master.frame({ops[i], 24'habcdef, 8'h5a}, nb[i]);
			k = 0;
			while (n_start == n0 && k < 100) begin
				@(negedge mclk);
				k++;
			end
			check(n_start, n0 + 1);
			check(32'(busy_seen), 32'h1);
			if (i == 5) begin
				check(32'(array_op.kind), 32'(FSW_KIND_PROG));
			end else begin
				check(32'(array_op.kind), i == 4 ? 32'(FSW_KIND_ALL) :
					32'(FSW_KIND_ERASE));
				check(32'(array_op.size_log2), 32'(sz[i]));
				check(32'(array_op.base),
					32'((24'h2bcdef >> sz[i]) << sz[i]));
			end
			wait_idle();
			check(32'(flash_status), 32'h00);
		end
		$display("test erase done");
	endtask

	task automatic t_quad();
		@(negedge mclk) quad_cmd = 1'b1;
		repeat (4) @(negedge mclk);
		i_master.qframe({OP_WRITE_ENABLE, 8'h00}, 2);
		check(32'(flash_status), 32'h02);
		i_master.qframe({OP_STATUS_READ, 8'h00}, 6);
		check(32'(i_master.rx), 32'h0202);
		i_master.qframe({OP_WRITE_DISABLE, 8'h00}, 2);
		check(32'(flash_status), 32'h00);
		@(negedge mclk) quad_cmd = 1'b0;
		repeat (4) @(negedge mclk);
		$display("test quad done");
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(negedge mclk);
		rstn = 1'b1;
		repeat (8) @(negedge mclk);
		t_reset();
		t_latch();
		t_refuse();
		t_status();
		t_erase();
		t_quad();
		print_verdict();
	end
endmodule // testbench
